/* rfpg_pkg.sv */
// package for the rail fault and power-good tree mask bank
package rfpg_pkg;
  localparam logic [7:0] RFPG_OFS_FAULT_MASK2 = 8'ha3;
  localparam logic [7:0] RFPG_OFS_PG_MASK1    = 8'ha4;
  localparam logic [7:0] RFPG_OFS_PG_MASK2    = 8'ha5;
  // fault mask register fields
  localparam int RFPG_FM_AUX_LDO_THREE = 0;
  localparam int RFPG_FM_SWITCH_B_ONE  = 1;
  localparam int RFPG_FM_SWITCH_B_TWO  = 2;
  localparam int RFPG_FM_DDR_TERM      = 3;
  localparam int RFPG_FM_AUX_LDO_ONE   = 4;
  localparam int RFPG_FM_RSVD_ONE      = 5;
  localparam int RFPG_FM_RSVD_ZERO     = 6;
  localparam int RFPG_FM_RSVD_RO       = 7;
  // writable bits of the fault mask register
  localparam logic [7:0] RFPG_FM_WMASK = 8'h7f;
  // reset values stand in for the factory variant
  localparam logic [7:0] RFPG_RST_FAULT_MASK2 = 8'h20;
  localparam logic [7:0] RFPG_RST_PG_MASK1    = 8'hff;
  localparam logic [7:0] RFPG_RST_PG_MASK2    = 8'hff;

  typedef struct packed {
    logic [7:0] fault_mask;
    logic [7:0] pg_mask1;
    logic [7:0] pg_mask2;
    logic [7:0] rdata;
    logic       pg_out;
    logic       shutdown;
  } rfpg_state_t;

  // register port request
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rfpg_req_t;
endpackage : rfpg_pkg

/* rfpg_bank.sv */
// rail fault mask and output one power-good tree bank
`timescale 1ns/1ps
module rfpg_bank
  import rfpg_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              sys_rst_i,
  // register port
  input  wire rfpg_pkg::rfpg_req_t req_i,
  output logic [7:0]             rdata_o,
  // rail faults: 0 aux ldo three, 1 sw b one, 2 sw b two, 3 ddr term, 4 aux ldo one
  input  wire logic [4:0]        rail_fault_i,
  // power good, mask one order: 0..7 = buck_controller_one,buck_controller_two,buck_controller_three,internal_buck_four,internal_buck_five,internal_buck_six,sw a1,ldo two
  input  wire logic [7:0]        pg_group1_i,
  // mask two order: 0 ldo three, 1 sw b1, 2 shared slot, 3 ddr term, 4..7 ctl 1,2,4,5
  input  wire logic [7:0]        pg_group2_i,
  // outputs
  output logic                   pg_output_one_o,
  output logic                   shutdown_req_o
);
  import rfpg_pkg::*;

  logic [4:0] flt_s1;
  logic [4:0] flt_s2;
  logic [7:0] pg1_s1;
  logic [7:0] pg1_s2;
  logic [7:0] pg2_s1;
  logic [7:0] pg2_s2;

  rfpg_state_t st;
  rfpg_state_t next_st;

  // pin inputs pass two flops
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      flt_s1 <= 5'h00;
      flt_s2 <= 5'h00;
      pg1_s1 <= 8'h00;
      pg1_s2 <= 8'h00;
      pg2_s1 <= 8'h00;
      pg2_s2 <= 8'h00;
    end
    else
    begin
      flt_s1 <= rail_fault_i;
      flt_s2 <= flt_s1;
      pg1_s1 <= pg_group1_i;
      pg1_s2 <= pg1_s1;
      pg2_s1 <= pg_group2_i;
      pg2_s2 <= pg2_s1;
    end
  end

  logic [7:0] pg1_ok;
  logic [7:0] pg2_ok;
  logic [4:0] flt_live;

  // per-bit mask: masked input counts as good, masked fault counts as none
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_pg
      assign pg1_ok[gi] = pg1_s2[gi] | st.pg_mask1[gi];
      assign pg2_ok[gi] = pg2_s2[gi] | st.pg_mask2[gi];
    end
    for (gi = 0; gi < 5; gi++)
    begin : g_flt
      assign flt_live[gi] = flt_s2[gi] & ~st.fault_mask[gi];
    end
  endgenerate

  always_comb
  begin
    next_st = st;
    if (req_i.wr_en)
    begin
      if (req_i.addr == RFPG_OFS_FAULT_MASK2)
        next_st.fault_mask = (st.fault_mask & ~RFPG_FM_WMASK) | (req_i.wdata & RFPG_FM_WMASK);
      else if (req_i.addr == RFPG_OFS_PG_MASK1)
        next_st.pg_mask1 = req_i.wdata;
      else if (req_i.addr == RFPG_OFS_PG_MASK2)
        next_st.pg_mask2 = req_i.wdata;
    end
    if (req_i.rd_en)
    begin
      if (req_i.addr == RFPG_OFS_FAULT_MASK2)
        next_st.rdata = st.fault_mask;
      else if (req_i.addr == RFPG_OFS_PG_MASK1)
        next_st.rdata = st.pg_mask1;
      else if (req_i.addr == RFPG_OFS_PG_MASK2)
        next_st.rdata = st.pg_mask2;
      else
        next_st.rdata = 8'h00;
    end
    next_st.pg_out   = &{pg1_ok, pg2_ok};
    next_st.shutdown = |flt_live;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st.fault_mask <= RFPG_RST_FAULT_MASK2;
      st.pg_mask1   <= RFPG_RST_PG_MASK1;
      st.pg_mask2   <= RFPG_RST_PG_MASK2;
      st.rdata      <= 8'h00;
      st.pg_out     <= 1'b0;
      st.shutdown   <= 1'b0;
    end
    else
      st <= next_st;
  end

  assign rdata_o         = st.rdata;
  assign pg_output_one_o = st.pg_out;
  assign shutdown_req_o  = st.shutdown;

  sequence fault_seen_s;
    flt_s2[RFPG_FM_AUX_LDO_ONE] && !st.fault_mask[RFPG_FM_AUX_LDO_ONE];
  endsequence

  fault_ldo1_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    fault_seen_s |=> shutdown_req_o) else $error("unmasked aux ldo one fault gave no shutdown");
  fault_ddr_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    flt_s2[RFPG_FM_DDR_TERM] && !st.fault_mask[RFPG_FM_DDR_TERM] |=> shutdown_req_o)
    else $error("unmasked ddr term fault gave no shutdown");
  fault_load_switch_b_two_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    flt_s2[RFPG_FM_SWITCH_B_TWO] && !st.fault_mask[RFPG_FM_SWITCH_B_TWO] |=> shutdown_req_o)
    else $error("unmasked switch b two fault gave no shutdown");
  fault_load_switch_b_one_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    flt_s2[RFPG_FM_SWITCH_B_ONE] && !st.fault_mask[RFPG_FM_SWITCH_B_ONE] |=> shutdown_req_o)
    else $error("unmasked switch b one fault gave no shutdown");
  fault_ldo3_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    flt_s2[RFPG_FM_AUX_LDO_THREE] && !st.fault_mask[RFPG_FM_AUX_LDO_THREE] |=> shutdown_req_o)
    else $error("unmasked aux ldo three fault gave no shutdown");
  masked_quiet_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (flt_live == 5'h00) |=> !shutdown_req_o) else $error("shutdown with no unmasked fault");
  pg_mask1_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (pg1_s2[0] == 1'b0 && st.pg_mask1[0] == 1'b0) |=> !pg_output_one_o)
    else $error("unmasked buck one low but output good");
  pg_mask2_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (pg2_s2[7] == 1'b0 && st.pg_mask2[7] == 1'b0) |=> !pg_output_one_o)
    else $error("unmasked control pin five low but output good");
  pg_all_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    ((pg1_s2 | st.pg_mask1) == 8'hff && (pg2_s2 | st.pg_mask2) == 8'hff) |=> pg_output_one_o)
    else $error("all unmasked inputs good but output not good");
  rsvd_bits_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    req_i.wr_en && req_i.addr == RFPG_OFS_FAULT_MASK2 |=> st.fault_mask[7] == $past(st.fault_mask[7]))
    else $error("read-only fault mask bit changed");

  // register port steps
  sequence fm_write_s;
    req_i.wr_en && (req_i.addr == RFPG_OFS_FAULT_MASK2);
  endsequence

  sequence pg1_write_s;
    req_i.wr_en && (req_i.addr == RFPG_OFS_PG_MASK1);
  endsequence

  sequence pg2_write_s;
    req_i.wr_en && (req_i.addr == RFPG_OFS_PG_MASK2);
  endsequence

  sequence odd_read_s;
    req_i.rd_en && (req_i.addr != RFPG_OFS_FAULT_MASK2) && (req_i.addr != RFPG_OFS_PG_MASK1) &&
      (req_i.addr != RFPG_OFS_PG_MASK2);
  endsequence

  sequence odd_write_s;
    req_i.wr_en && (req_i.addr != RFPG_OFS_FAULT_MASK2) && (req_i.addr != RFPG_OFS_PG_MASK1) &&
      (req_i.addr != RFPG_OFS_PG_MASK2);
  endsequence

  fm_write_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    fm_write_s |=> st.fault_mask[6:0] == $past(req_i.wdata[6:0]))
    else $error("fault mask write did not land");

  pg1_write_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    pg1_write_s |=> st.pg_mask1 == $past(req_i.wdata))
    else $error("pg mask one write did not land");

  pg2_write_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    pg2_write_s |=> st.pg_mask2 == $past(req_i.wdata))
    else $error("pg mask two write did not land");

  odd_write_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    odd_write_s |=> (st.fault_mask == $past(st.fault_mask)) && (st.pg_mask1 == $past(st.pg_mask1)) &&
      (st.pg_mask2 == $past(st.pg_mask2)))
    else $error("write to unmapped offset changed a register");

  fm_read_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (req_i.rd_en && req_i.addr == RFPG_OFS_FAULT_MASK2) |=> rdata_o == $past(st.fault_mask))
    else $error("fault mask read returned wrong data");

  pg1_read_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (req_i.rd_en && req_i.addr == RFPG_OFS_PG_MASK1) |=> rdata_o == $past(st.pg_mask1))
    else $error("pg mask one read returned wrong data");

  pg2_read_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (req_i.rd_en && req_i.addr == RFPG_OFS_PG_MASK2) |=> rdata_o == $past(st.pg_mask2))
    else $error("pg mask two read returned wrong data");

  odd_read_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    odd_read_s |=> rdata_o == 8'h00)
    else $error("read of unmapped offset not zero");

  rdata_hold_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !req_i.rd_en |=> $stable(rdata_o))
    else $error("read data moved without a read");

  // masked faults stay quiet on their own
  ldo1_masked_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (flt_s2 == 5'h10 && st.fault_mask[RFPG_FM_AUX_LDO_ONE]) |=> !shutdown_req_o)
    else $error("masked aux ldo one fault gave shutdown");

  ddr_masked_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (flt_s2 == 5'h08 && st.fault_mask[RFPG_FM_DDR_TERM]) |=> !shutdown_req_o)
    else $error("masked ddr term fault gave shutdown");

  load_switch_b_two_masked_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (flt_s2 == 5'h04 && st.fault_mask[RFPG_FM_SWITCH_B_TWO]) |=> !shutdown_req_o)
    else $error("masked switch b two fault gave shutdown");

  load_switch_b_one_masked_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (flt_s2 == 5'h02 && st.fault_mask[RFPG_FM_SWITCH_B_ONE]) |=> !shutdown_req_o)
    else $error("masked switch b one fault gave shutdown");

  ldo3_masked_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (flt_s2 == 5'h01 && st.fault_mask[RFPG_FM_AUX_LDO_THREE]) |=> !shutdown_req_o)
    else $error("masked aux ldo three fault gave shutdown");

  // each unmasked power good input pulls the tree low
  pg_buck_controller_two_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!pg1_s2[1] && !st.pg_mask1[1]) |=> !pg_output_one_o)
    else $error("unmasked buck two low but output good");

  pg_buck_controller_three_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!pg1_s2[2] && !st.pg_mask1[2]) |=> !pg_output_one_o)
    else $error("unmasked buck three low but output good");

  pg_internal_buck_four_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!pg1_s2[3] && !st.pg_mask1[3]) |=> !pg_output_one_o)
    else $error("unmasked buck four low but output good");

  pg_internal_buck_five_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!pg1_s2[4] && !st.pg_mask1[4]) |=> !pg_output_one_o)
    else $error("unmasked buck five low but output good");

  pg_internal_buck_six_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!pg1_s2[5] && !st.pg_mask1[5]) |=> !pg_output_one_o)
    else $error("unmasked buck six low but output good");

  pg_load_switch_a_one_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!pg1_s2[6] && !st.pg_mask1[6]) |=> !pg_output_one_o)
    else $error("unmasked switch a one low but output good");

  pg_ldo2_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!pg1_s2[7] && !st.pg_mask1[7]) |=> !pg_output_one_o)
    else $error("unmasked aux ldo two low but output good");

  pg_ldo3_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!pg2_s2[0] && !st.pg_mask2[0]) |=> !pg_output_one_o)
    else $error("unmasked aux ldo three low but output good");

  pg_load_switch_b_one_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!pg2_s2[1] && !st.pg_mask2[1]) |=> !pg_output_one_o)
    else $error("unmasked switch b one low but output good");

  pg_shared_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!pg2_s2[2] && !st.pg_mask2[2]) |=> !pg_output_one_o)
    else $error("unmasked shared slot low but output good");

  pg_ddr_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!pg2_s2[3] && !st.pg_mask2[3]) |=> !pg_output_one_o)
    else $error("unmasked ddr term low but output good");

  pg_control_pin_one_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!pg2_s2[4] && !st.pg_mask2[4]) |=> !pg_output_one_o)
    else $error("unmasked control pin one low but output good");

  pg_control_pin_two_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!pg2_s2[5] && !st.pg_mask2[5]) |=> !pg_output_one_o)
    else $error("unmasked control pin two low but output good");

  pg_control_pin_four_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!pg2_s2[6] && !st.pg_mask2[6]) |=> !pg_output_one_o)
    else $error("unmasked control pin four low but output good");

  pg_low_any_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    ((pg1_s2 | st.pg_mask1) != 8'hff || (pg2_s2 | st.pg_mask2) != 8'hff) |=> !pg_output_one_o)
    else $error("an unmasked input is low but output good");

endmodule : rfpg_bank

/* rfpg_tb.sv */
// self-checking bench for the rail fault and power-good tree mask bank
`timescale 1ns/1ps
module testbench;
  import rfpg_pkg::*;
  logic       core_clk_i = 1'b0;
  logic       sys_rst_i  = 1'b1;
  rfpg_req_t  req_i      = '0;
  logic [4:0] rail_fault_i = 5'h00;
  logic [7:0] pg_group1_i  = 8'h00;
  logic [7:0] pg_group2_i  = 8'h00;
  logic [7:0] rdata_o;
  logic       pg_output_one_o;
  logic       shutdown_req_o;
  int         miscompares = 0;
  int         samples_checked = 0;
  int         i;
  always #2 core_clk_i = ~core_clk_i;
  rfpg_bank dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i), .rdata_o(rdata_o),
    .rail_fault_i(rail_fault_i), .pg_group1_i(pg_group1_i), .pg_group2_i(pg_group2_i),
    .pg_output_one_o(pg_output_one_o), .shutdown_req_o(shutdown_req_o));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk_reg
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %b exp %b", $time, msg, got, exp);
    end
  endtask : chk_bit
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    req_i <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    @(posedge core_clk_i);
    req_i.wr_en <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    req_i <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk_i);
    req_i.rd_en <= 1'b0;
    #1;
    chk_reg(rdata_o, exp, "register read");
  endtask : rd_chk
  task automatic settle;
    repeat (4) @(posedge core_clk_i);
    #1;
  endtask : settle
  initial
  begin
    #100000;
    miscompares++;
    end_sim();
  end
  initial
  begin
    repeat (8) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    rd_chk(RFPG_OFS_FAULT_MASK2, RFPG_RST_FAULT_MASK2);
    rd_chk(RFPG_OFS_PG_MASK1, RFPG_RST_PG_MASK1);
    rd_chk(RFPG_OFS_PG_MASK2, RFPG_RST_PG_MASK2);
    rd_chk(8'ha6, 8'h00);
    wr(8'ha6, 8'h00);
    rd_chk(RFPG_OFS_PG_MASK1, RFPG_RST_PG_MASK1);
    rd_chk(RFPG_OFS_PG_MASK2, RFPG_RST_PG_MASK2);
    settle();
    chk_bit(pg_output_one_o, 1'b1, "fully masked tree");
    wr(RFPG_OFS_FAULT_MASK2, 8'hbf);
    rd_chk(RFPG_OFS_FAULT_MASK2, 8'h3f);
    wr(RFPG_OFS_PG_MASK1, 8'h5a);
    rd_chk(RFPG_OFS_PG_MASK1, 8'h5a);
    wr(RFPG_OFS_PG_MASK2, 8'ha5);
    rd_chk(RFPG_OFS_PG_MASK2, 8'ha5);
    $display("test registers done");
    for (i = 0; i < 5; i++)
    begin
      wr(RFPG_OFS_FAULT_MASK2, 8'h20);
      @(posedge core_clk_i);
      rail_fault_i <= 5'(1 << i);
      settle();
      chk_bit(shutdown_req_o, 1'b1, "unmasked fault");
      wr(RFPG_OFS_FAULT_MASK2, 8'h20 | 8'(1 << i));
      settle();
      chk_bit(shutdown_req_o, 1'b0, "masked fault");
    end
    rail_fault_i <= 5'h00;
    $display("test fault masks done");
    for (i = 0; i < 16; i++)
    begin
      wr(RFPG_OFS_PG_MASK1, 8'h00);
      wr(RFPG_OFS_PG_MASK2, 8'h00);
      @(posedge core_clk_i);
      {pg_group2_i, pg_group1_i} <= 16'hffff;
      settle();
      chk_bit(pg_output_one_o, 1'b1, "all inputs good");
      {pg_group2_i, pg_group1_i} <= ~16'(1 << i);
      settle();
      chk_bit(pg_output_one_o, 1'b0, "unmasked input bad");
      wr(RFPG_OFS_PG_MASK1, 8'(1 << i));
      wr(RFPG_OFS_PG_MASK2, 8'((1 << i) >> 8));
      settle();
      chk_bit(pg_output_one_o, 1'b1, "masked input bad");
    end
    $display("test power good tree done");
    end_sim();
  end
endmodule : testbench
